// *** include/dbs_pkg.sv ***
// Shared constants and types for the dynamic bus sizing block
package dbs_pkg;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ADDR_W = 30;
  localparam logic [3:0] BE_IDLE_N = 4'hF;
  localparam logic [3:0] HALF_LOW = 4'h3;
  localparam logic [3:0] HALF_HIGH = 4'hC;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DBS_W32,
    DBS_W16,
    DBS_W8
  } dbs_width_t;

  typedef enum logic [1:0] {
    DBS_IDLE,
    DBS_ADDR,
    DBS_WAIT
  } dbs_state_t;
endpackage

// *** design/dbs_lane_table.sv ***
// Next byte-enable and read-capture lane table for narrow bus cycles
`timescale 1ns/1ps
module dbs_lane_table (
  input wire dbs_pkg::dbs_width_t width,
  input wire logic [3:0] cur_be_n,
  output logic [3:0] next_be_n,
  output logic more,
  output logic [3:0] capture_mask
);

  // ----------------------------------------
  // Lowest active lane, one-hot
  // ----------------------------------------
  function automatic logic [3:0] lowest_lane(input logic [3:0] act);
    lowest_lane = act & (~act + 4'h1);
  endfunction

  logic [3:0] act;
  logic [3:0] low;
  logic lo_any;
  logic hi_any;

  always_comb begin
    act = ~cur_be_n;
    low = lowest_lane(act);
    lo_any = |act[1:0];
    hi_any = |act[3:2];
    next_be_n = cur_be_n;
    more = 1'b0;
    capture_mask = act;
    unique case (width)
      dbs_pkg::DBS_W8: begin
        // Drop the byte just moved; a lone byte ends the request
        more = (act & ~low) != 4'h0;
        next_be_n = cur_be_n | low;
        capture_mask = low;
      end
      dbs_pkg::DBS_W16: begin
        // Only a request straddling both halves needs a second cycle
        more = lo_any && hi_any;
        next_be_n = cur_be_n | dbs_pkg::HALF_LOW;
        capture_mask = lo_any ? (act & dbs_pkg::HALF_LOW) : (act & dbs_pkg::HALF_HIGH);
      end
      dbs_pkg::DBS_W32: begin
        more = 1'b0;
        next_be_n = cur_be_n;
        capture_mask = act;
      end
      default: begin
        more = 1'b0;
        next_be_n = cur_be_n;
        capture_mask = act;
      end
    endcase
  end
endmodule

// *** design/dbs_sizer.sv ***
// Bus cycle sequencer that splits requests for 32, 16 and 8 bit devices
//
// Overview of operation
// - Width sampled anew on every bus cycle
// - Sixteen-bit width splits dword into two cycles
// - Eight-bit width splits dword into four cycles
// - Extra cycles change enables only, address steady
// - Eight-bit next-enable table, single bytes finish
// - Sixteen-bit next-enable table, listed patterns finish
// - No extra cycle once bytes are covered
// - Capture lowest byte, lowest half, or all
// - Write data only on enabled lanes
// - Request enables pass through unchecked; a_no_gap flags gaps between lanes
`timescale 1ns/1ps
module dbs_sizer (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [29:0] req_word_address,
  input wire logic [3:0] req_byte_enables_n,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic bus_start,
  output logic bus_write,
  output logic [29:0] word_address,
  output logic [3:0] byte_lane_enables_n,
  output logic [31:0] data_lanes_out,
  output logic data_lanes_oe,
  input wire logic [31:0] data_lanes_in,
  input wire logic bus_ready_n,
  input wire logic width16_request_n,
  input wire logic width8_request_n
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] m);
    lane_mask = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  function automatic dbs_pkg::dbs_width_t decode_width(input logic w16_n, input logic w8_n);
    if (!w8_n) begin
      decode_width = dbs_pkg::DBS_W8;
    end else if (!w16_n) begin
      decode_width = dbs_pkg::DBS_W16;
    end else begin
      decode_width = dbs_pkg::DBS_W32;
    end
  endfunction

  function automatic logic no_gap(input logic [3:0] be_n);
    logic [3:0] a;
    a = ~be_n;
    no_gap = !(a == 4'h5 || a == 4'h9 || a == 4'hA || a == 4'hB || a == 4'hD);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  dbs_pkg::dbs_state_t state_r, state_nxt;
  logic [29:0] addr_r, addr_nxt;
  logic [3:0] be_r, be_nxt;
  logic write_r, write_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic resp_r, resp_nxt;
  logic start_r, start_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;

  dbs_pkg::dbs_width_t width_now;
  logic [3:0] tbl_next_be_n;
  logic tbl_more;
  logic [3:0] tbl_capture;
  logic cycle_done;

  assign width_now = decode_width(width16_request_n, width8_request_n);
  assign cycle_done = (state_r == dbs_pkg::DBS_WAIT) && !bus_ready_n;

  dbs_lane_table u_table (
    .width(width_now),
    .cur_be_n(be_r),
    .next_be_n(tbl_next_be_n),
    .more(tbl_more),
    .capture_mask(tbl_capture)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    be_nxt = be_r;
    write_nxt = write_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    resp_nxt = 1'b0;
    start_nxt = 1'b0;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    unique case (state_r)
      dbs_pkg::DBS_IDLE: begin
        if (req_valid) begin
          state_nxt = dbs_pkg::DBS_ADDR;
          addr_nxt = req_word_address;
          be_nxt = req_byte_enables_n;
          write_nxt = req_write;
          wdata_nxt = req_wdata;
          rdata_nxt = dbs_pkg::DATA_ZERO;
          start_nxt = 1'b1;
          // Disabled lanes carry zero, never a copy of the data
          dout_nxt = req_wdata & lane_mask(~req_byte_enables_n);
          oe_nxt = req_write;
        end
      end
      dbs_pkg::DBS_ADDR: begin
        state_nxt = dbs_pkg::DBS_WAIT;
      end
      dbs_pkg::DBS_WAIT: begin
        if (!bus_ready_n) begin
          if (!write_r) begin
            rdata_nxt = (rdata_r & ~lane_mask(tbl_capture)) | (data_lanes_in & lane_mask(tbl_capture));
          end
          if (tbl_more) begin
            // Word address held; only the enables advance
            state_nxt = dbs_pkg::DBS_ADDR;
            be_nxt = tbl_next_be_n;
            start_nxt = 1'b1;
            dout_nxt = wdata_r & lane_mask(~tbl_next_be_n);
          end else begin
            state_nxt = dbs_pkg::DBS_IDLE;
            resp_nxt = 1'b1;
            oe_nxt = 1'b0;
            be_nxt = dbs_pkg::BE_IDLE_N;
            dout_nxt = dbs_pkg::DATA_ZERO;
          end
        end
      end
      default: begin
        state_nxt = dbs_pkg::DBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dbs_pkg::DBS_IDLE;
      addr_r <= 30'h0000_0000;
      be_r <= dbs_pkg::BE_IDLE_N;
      write_r <= 1'b0;
      wdata_r <= dbs_pkg::DATA_ZERO;
      rdata_r <= dbs_pkg::DATA_ZERO;
      resp_r <= 1'b0;
      start_r <= 1'b0;
      dout_r <= dbs_pkg::DATA_ZERO;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      be_r <= be_nxt;
      write_r <= write_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
      start_r <= start_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready = (state_r == dbs_pkg::DBS_IDLE);
  assign resp_valid = resp_r;
  assign resp_rdata = rdata_r;
  assign bus_start = start_r;
  assign bus_write = write_r;
  assign word_address = addr_r;
  assign byte_lane_enables_n = be_r;
  assign data_lanes_out = dout_r;
  assign data_lanes_oe = oe_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_addr_held: assert property ((state_r != dbs_pkg::DBS_IDLE) && ($past(state_r) != dbs_pkg::DBS_IDLE)
    |-> $stable(word_address)) else $error("word address moved inside a request");
  a_w8_step: assert property (cycle_done && !width8_request_n && be_r == 4'h0
    |=> byte_lane_enables_n == 4'h1 && bus_start) else $error("byte split step wrong");
  a_w8_chain: assert property (cycle_done && !width8_request_n && be_r == 4'h1
    |=> byte_lane_enables_n == 4'h3) else $error("byte split chain wrong");
  a_w16_step: assert property (cycle_done && width8_request_n && !width16_request_n && be_r == 4'h8
    |=> byte_lane_enables_n == 4'hB) else $error("half split step wrong");
  a_w16_done: assert property (cycle_done && width8_request_n && !width16_request_n && be_r == 4'hC
    |=> resp_valid && !bus_start) else $error("half request not finished");
  a_w32_done: assert property (cycle_done && width8_request_n && width16_request_n
    |=> resp_valid) else $error("full width request took extra cycle");
  a_both_low: assert property (cycle_done && !width8_request_n && !width16_request_n && be_r == 4'h3
    |=> byte_lane_enables_n == 4'h7) else $error("both widths not taken as byte");
  a_no_gap: assert property (bus_start |-> no_gap(byte_lane_enables_n))
    else $error("gapped byte enables issued");
  a_write_lanes: assert property (bus_start && data_lanes_oe
    |-> (data_lanes_out & ~lane_mask(~byte_lane_enables_n)) == 32'h0000_0000)
    else $error("write data on disabled lane");
  a_start_gap: assert property (bus_start |=> !bus_start)
    else $error("bus start not single pulse");

  c_byte_split: cover property (cycle_done && !width8_request_n && be_r == 4'h0);
  c_half_split: cover property (cycle_done && !width16_request_n && width8_request_n && be_r == 4'h0);
  c_full_write: cover property (cycle_done && write_r && width8_request_n && width16_request_n);
  c_both_low: cover property (cycle_done && !width8_request_n && !width16_request_n);
endmodule

// *** tb/dbs_mem_model.sv ***
// Memory or I/O device model with width decode and per-lane data select
`timescale 1ns/1ps
module dbs_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_start,
  input wire logic [29:0] word_address,
  input wire logic [3:0] byte_lane_enables_n,
  input wire dbs_pkg::dbs_width_t width_sel,
  input wire logic [1:0] delay,
  output logic bus_ready_n,
  output logic width16_request_n,
  output logic width8_request_n,
  output logic [31:0] data_lanes_in
);
  // ----------------------------------------
  // Decode and answer
  // ----------------------------------------
  logic busy_r;
  logic [1:0] cnt_r;
  logic [31:0] word;
  logic [3:0] sel;
  logic [3:0] act;
  logic both_low;
  logic byte_mode;
  logic addr_bit1;
  logic upper_byte_select_n;
  logic lower_byte_select_n;
  assign word = {word_address[5:0], 2'h3, word_address[5:0], 2'h2, word_address[5:0], 2'h1, word_address[5:0], 2'h0};
  // Spare width code pulls both width inputs low at once
  assign both_low = (width_sel == dbs_pkg::dbs_width_t'(2'h3));
  assign byte_mode = (width_sel == dbs_pkg::DBS_W8) || both_low;
  assign width16_request_n = !(busy_r && (width_sel == dbs_pkg::DBS_W16 || both_low));
  assign width8_request_n = !(busy_r && byte_mode);
  // Byte selects decoded from the enables, shared by both narrow widths
  assign act = ~byte_lane_enables_n;
  assign addr_bit1 = (act[1:0] == 2'h0);
  assign lower_byte_select_n = addr_bit1 ? !act[2] : !act[0];
  assign upper_byte_select_n = addr_bit1 ? !act[3] : !act[1];
  always_comb begin
    sel = act;
    if (byte_mode) begin
      sel = 4'h1 << {addr_bit1, lower_byte_select_n};
    end else if (width_sel == dbs_pkg::DBS_W16) begin
      if (addr_bit1) begin
        sel = {!upper_byte_select_n, !lower_byte_select_n, 2'h0};
      end else begin
        sel = {2'h0, !upper_byte_select_n, !lower_byte_select_n};
      end
    end
  end
  // Unused lanes carry the inverse, so a wrong capture never matches
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data_lanes_in[8*i +: 8] = (!bus_ready_n && sel[i]) ? word[8*i +: 8] : ~word[8*i +: 8];
    end
  end
  always_ff @(posedge clk) begin
    if (rst || (busy_r && !bus_ready_n)) begin
      busy_r <= 1'b0;
      bus_ready_n <= 1'b1;
    end else if (bus_start) begin
      busy_r <= 1'b1;
      cnt_r <= delay;
      bus_ready_n <= (delay == 2'h0) ? 1'b0 : 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 2'h1;
      bus_ready_n <= (cnt_r == 2'h1) ? 1'b0 : 1'b1;
    end
  end
endmodule

// *** tb/dbs_sizer_tb.sv ***
// Self-checking bench for the dynamic bus sizing sequencer
`timescale 1ns/1ps
module dbs_sizer_tb;
  // ----------------------------------------
  // Clock, design and device
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [29:0] req_addr = 30'h0;
  logic [3:0] req_be = 4'hF;
  logic [31:0] req_wdata = 32'h0;
  dbs_pkg::dbs_width_t width_sel = dbs_pkg::DBS_W32;
  logic [1:0] delay = 2'h0;
  logic req_ready, resp_valid, bus_start, bus_write, oe, rdy_n, w16_n, w8_n;
  logic [29:0] word_address;
  logic [3:0] be_n;
  logic [31:0] rdata, dout, din;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [3:0] seq[$];
  always #20 clk = ~clk;
  dbs_sizer i_dbs_sizer (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_word_address(req_addr), .req_byte_enables_n(req_be), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_rdata(rdata), .bus_start(bus_start), .bus_write(bus_write),
    .word_address(word_address), .byte_lane_enables_n(be_n), .data_lanes_out(dout), .data_lanes_oe(oe),
    .data_lanes_in(din), .bus_ready_n(rdy_n), .width16_request_n(w16_n), .width8_request_n(w8_n));
  dbs_mem_model i_dbs_mem_model (.clk(clk), .rst(rst), .bus_start(bus_start), .word_address(word_address),
    .byte_lane_enables_n(be_n), .width_sel(width_sel), .delay(delay), .bus_ready_n(rdy_n),
    .width16_request_n(w16_n), .width8_request_n(w8_n), .data_lanes_in(din));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  function automatic logic [31:0] lanes(input logic [3:0] b);
    return {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
  endfunction
  function automatic logic [31:0] pat(input logic [29:0] a);
    return {a[5:0], 2'h3, a[5:0], 2'h2, a[5:0], 2'h1, a[5:0], 2'h0};
  endfunction
  function automatic logic [3:0] nxt(input int w, input logic [3:0] b);
    logic [3:0] on;
    on = ~b;
    if (w >= 2) return b | (on & (~on + 4'h1));
    if (w == 1 && b[1:0] != 2'h3) return b | 4'h3;
    return 4'hF;
  endfunction
  always @(negedge clk) begin
    if (!rst && bus_start) begin
      seq.push_back(be_n);
      check(word_address, req_addr, "address");
      check(bus_write, req_write, "direction");
      check(be_n inside {4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h9, 4'h3, 4'h8, 4'h1, 4'h0}, 1'b1, "gap");
      if (bus_write) check(dout, req_wdata & lanes(be_n), "wdata");
    end
  end
  // One request at a falling edge, then the whole split sequence is judged
  task automatic run(input int w, input logic wr, input logic [3:0] be, input logic [1:0] dly);
    logic [3:0] exp_be;
    int n;
    width_sel = dbs_pkg::dbs_width_t'(w);
    delay = dly;
    req_write = wr;
    req_addr = req_addr + 30'h5;
    req_be = be;
    req_wdata = {req_addr[7:0], ~req_addr[7:0], 16'hC35A};
    seq.delete();
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(resp_valid, 1'b1, "done");
    exp_be = be;
    foreach (seq[i]) begin
      check(seq[i], exp_be, "enables");
      exp_be = nxt(w, exp_be);
    end
    check(exp_be, 4'hF, "cycle count");
    if (!wr) check(rdata & lanes(be), pat(req_addr) & lanes(be), "rdata");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_aligned();
    for (int w = 0; w < 4; w++) run(w, 1'b0, 4'h0, 2'h0);
    $display("test aligned done");
  endtask
  task automatic t_table();
    logic [3:0] pats[10] = '{4'hE, 4'hC, 4'h8, 4'h0, 4'hD, 4'h9, 4'h1, 4'hB, 4'h3, 4'h7};
    for (int w = 0; w < 4; w++)
      foreach (pats[i]) run(w, 1'b0, pats[i], 2'(i % 4));
    $display("test table done");
  endtask
  task automatic t_write();
    for (int w = 0; w < 3; w++) begin
      run(w, 1'b1, 4'h8, 2'h3);
      run(w, 1'b1, 4'h1, 2'h1);
    end
    $display("test write done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check({req_ready, resp_valid, oe, be_n}, 7'h4F, "reset");
    t_aligned();
    t_table();
    t_write();
    finish_test();
  end
endmodule
